/* core/irq_map_pkg.sv */
// Constants and types for the bridge interrupt mapper
// Summary of operation
// - Legacy interrupts on the express side travel only as message packets.
// - On the PCI side either the four pins or MSI is used, and MSI disables the pins.
// - MSI writes carry a full 64-bit address.
// - In reverse mode received messages drive pins; with MSI enabled, only an assert that raises a line makes an MSI write.
// - In forward mode pin activity or PCI-side MSI becomes upstream messages.
// - Exactly eight message types exist: assert and deassert for lines A to D.
// - In forward mode with MSI off the four PCI pins are watched; each line whose level differs from the reported one is translated.
// - Reverse mapping is one-to-one: line A to pin A through line D to pin D.
// - Forward mapping is one-to-one: pin A to line A through pin D to line D.
package irq_map_pkg;
  localparam int NUM_LINES = 4;
  localparam int LINE_W = 2;
  localparam int MSI_ADDR_W = 64;
  localparam int MSI_DATA_W = 32;
  // Message type code: bit 2 set for assert, low bits pick the line
  localparam int MSG_W = 3;
  localparam int MSG_ASSERT_BIT = 2;
  localparam logic [MSG_W-1:0] MSG_IDLE = 3'h0;
  localparam logic [NUM_LINES-1:0] LINES_RESET = 4'h0;
  localparam logic [LINE_W-1:0] LINE_ZERO = 2'h0;
  localparam logic [MSI_ADDR_W-1:0] ADDR_ZERO = 64'h0000_0000_0000_0000;
  localparam logic [MSI_DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } tx_state_e;
endpackage

/* core/bridge_interrupt_mapper.sv */
// Legacy interrupt translation between express messages and PCI pins/MSI
`timescale 1ns/1ps
module bridge_interrupt_mapper
  import irq_map_pkg::*;
(
  input wire logic core_clk, // 40 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic reverse_mode, // 1 reverse bridge, 0 forward
  input wire logic msi_enable, // MSI enable config bit
  input wire logic [MSI_ADDR_W-1:0] msi_addr, // MSI target address
  input wire logic [MSI_DATA_W-1:0] msi_data, // MSI payload
  input wire logic rx_msg_valid, // Received message strobe
  input wire logic [MSG_W-1:0] rx_msg_type, // Received assert/deassert code
  input wire logic [NUM_LINES-1:0] pci_int_n_in, // PCI INTA..D pin levels
  input wire logic pci_msi_valid, // MSI write seen on PCI side
  input wire logic [LINE_W-1:0] pci_msi_line, // Line that PCI MSI maps to
  input wire logic tx_msg_ready, // Upstream accepts a message
  input wire logic msi_wr_ready, // Host side accepts MSI write
  output logic [NUM_LINES-1:0] pci_int_n_out, // Pin drive value (low)
  output logic [NUM_LINES-1:0] pci_int_oe_n, // Pin enable, low drives
  output logic tx_msg_valid, // Outgoing message strobe
  output logic [MSG_W-1:0] tx_msg_type, // Outgoing message code
  output logic msi_wr_valid, // MSI write request
  output logic [MSI_ADDR_W-1:0] msi_wr_addr, // MSI write address
  output logic [MSI_DATA_W-1:0] msi_wr_data // MSI write data
);
  logic [NUM_LINES-1:0] rev_state_r; // Virtual line levels, reverse
  logic [NUM_LINES-1:0] fwd_state_r; // Reported levels, forward
  logic [NUM_LINES-1:0] msi_pend_r;
  logic [NUM_LINES-1:0] pins_asserted;
  logic [NUM_LINES-1:0] fwd_diff;
  logic [LINE_W-1:0] fwd_pick;
  logic [LINE_W-1:0] msi_pick;
  logic [NUM_LINES-1:0] rx_set;
  logic [NUM_LINES-1:0] rx_clr;
  logic [NUM_LINES-1:0] msi_take;
  logic [NUM_LINES-1:0] fwd_take;
  logic pci_msi_fwd;
  logic pin_launch;
  logic tx_start;
  logic msi_launch;
  logic [LINE_W-1:0] msi_line_r; // Line of the write in flight
  logic tx_msi_r; // Message in flight came from PCI-side MSI
  tx_state_e tx_state_r;

  // Decode the eight message codes to per-line set/clear
  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_line
      assign rx_set[g] = reverse_mode && rx_msg_valid
          && rx_msg_type[LINE_W-1:0] == LINE_W'(g)
          && rx_msg_type[MSG_ASSERT_BIT];
      assign rx_clr[g] = reverse_mode && rx_msg_valid
          && rx_msg_type[LINE_W-1:0] == LINE_W'(g)
          && !rx_msg_type[MSG_ASSERT_BIT];
      assign pins_asserted[g] = !pci_int_n_in[g];
      assign msi_take[g] = msi_wr_valid && msi_wr_ready
          && msi_line_r == LINE_W'(g);
      assign fwd_take[g] = tx_state_r == ST_SEND && tx_msg_ready
          && !tx_msi_r && tx_msg_type[LINE_W-1:0] == LINE_W'(g);
    end
  endgenerate

  assign fwd_diff = pins_asserted ^ fwd_state_r;
  assign pci_msi_fwd = !reverse_mode && msi_enable && pci_msi_valid;
  assign pin_launch = !reverse_mode && !msi_enable && |fwd_diff;
  assign tx_start = tx_state_r == ST_IDLE && (pci_msi_fwd || pin_launch);
  assign msi_launch = !msi_wr_valid && |msi_pend_r
      && reverse_mode && msi_enable;

  // Lowest changed line first; fixed priority keeps pick deterministic
  always_comb begin
    fwd_pick = LINE_ZERO;
    msi_pick = LINE_ZERO;
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (fwd_diff[i]) begin
        fwd_pick = i[LINE_W-1:0];
      end
      if (msi_pend_r[i]) begin
        msi_pick = i[LINE_W-1:0];
      end
    end
  end

  // Reverse: virtual line level held until its deassert message
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rev_state_r <= LINES_RESET;
    end else if (!reverse_mode) begin
      rev_state_r <= LINES_RESET;
    end else begin
      rev_state_r <= (rev_state_r & ~rx_clr) | rx_set;
    end
  end

  // Open-drain model: the value is always low, the enable decides
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pci_int_n_out <= LINES_RESET;
    end else begin
      pci_int_n_out <= LINES_RESET;
    end
  end

  // Pins drive only when MSI is off; low enable pulls the pin low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pci_int_oe_n <= ~LINES_RESET;
    end else if (reverse_mode && !msi_enable) begin
      pci_int_oe_n <= ~rev_state_r;
    end else begin
      pci_int_oe_n <= ~LINES_RESET;
    end
  end

  // One MSI write per rising line; new rise wins over a same-cycle take
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msi_pend_r <= LINES_RESET;
    end else if (!(reverse_mode && msi_enable)) begin
      msi_pend_r <= LINES_RESET;
    end else begin
      msi_pend_r <= (msi_pend_r & ~msi_take)
          | (rx_set & ~rev_state_r);
    end
  end

  // Write request stands until the host side takes it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msi_wr_valid <= 1'b0;
    end else if (msi_wr_valid) begin
      if (msi_wr_ready) begin
        msi_wr_valid <= 1'b0;
      end
    end else if (msi_launch) begin
      msi_wr_valid <= 1'b1;
    end
  end

  // Line of the write in flight; a lower line rising meanwhile must
  // not steal the take, or this line would be written twice
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msi_line_r <= LINE_ZERO;
    end else if (msi_launch) begin
      msi_line_r <= msi_pick;
    end
  end

  // Address and data captured at launch, held while the request stands
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msi_wr_addr <= ADDR_ZERO;
      msi_wr_data <= DATA_ZERO;
    end else if (msi_launch) begin
      msi_wr_addr <= msi_addr;
      msi_wr_data <= msi_data;
    end
  end

  // Forward: reported state follows what was actually sent upstream
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_state_r <= LINES_RESET;
    end else if (reverse_mode) begin
      fwd_state_r <= LINES_RESET;
    end else begin
      fwd_state_r <= fwd_state_r ^ fwd_take;
    end
  end

  // Message sender; one message in flight, held until taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_r <= ST_IDLE;
    end else begin
      unique case (tx_state_r)
        ST_IDLE: begin
          if (tx_start) begin
            tx_state_r <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tx_msg_ready) begin
            tx_state_r <= ST_IDLE;
          end
        end
        default: begin
          tx_state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Packets, not wires: the strobe marks one message at a time
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_msg_valid <= 1'b0;
    end else if (tx_start) begin
      tx_msg_valid <= 1'b1;
    end else if (tx_state_r != ST_SEND || tx_msg_ready) begin
      tx_msg_valid <= 1'b0;
    end
  end

  // Code held unchanged until the far side takes it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_msg_type <= MSG_IDLE;
    end else if (tx_start && pci_msi_fwd) begin
      tx_msg_type <= {1'b1, pci_msi_line};
    end else if (tx_start) begin
      tx_msg_type <= {pins_asserted[fwd_pick], fwd_pick};
    end
  end

  // PCI-side MSI messages must not move the reported pin state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_msi_r <= 1'b0;
    end else if (tx_start) begin
      tx_msi_r <= pci_msi_fwd;
    end
  end
endmodule

/* verif/irq_map_partner.sv */
// Far-side sink for upstream messages and MSI writes
`timescale 1ns/1ps
module irq_map_partner (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic tx_msg_valid, // Message offered
  input wire logic [2:0] tx_msg_type, // Message code
  input wire logic msi_wr_valid, // Write offered
  output logic ready, // Accept
  output logic [7:0] n_tx, // Messages taken
  output logic [7:0] n_msi, // Writes taken
  output logic [2:0] last_tx // Last code taken
);
  // Stalls every other cycle so the mapper must hold its requests
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'h0;
      n_tx <= 8'h00;
      n_msi <= 8'h00;
      last_tx <= 3'h0;
    end else begin
      if (tx_msg_valid && ready) begin
        last_tx <= tx_msg_type;
      end
      ready <= ~ready;
      n_tx <= n_tx + 8'(tx_msg_valid & ready);
      n_msi <= n_msi + 8'(msi_wr_valid & ready);
    end
  end
endmodule

/* verif/bridge_interrupt_mapper_chk.sv */
// Port assertions for the interrupt mapper
`timescale 1ns/1ps
module bridge_interrupt_mapper_chk
  import irq_map_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic reverse_mode, // Mode
  input wire logic msi_enable, // MSI on
  input wire logic [MSI_ADDR_W-1:0] msi_addr, // Address
  input wire logic rx_msg_valid, // Rx strobe
  input wire logic [MSG_W-1:0] rx_msg_type, // Rx code
  input wire logic [NUM_LINES-1:0] pci_int_n_in, // Pins
  input wire logic tx_msg_ready, // Tx ready
  input wire logic msi_wr_ready, // MSI ready
  input wire logic [NUM_LINES-1:0] pci_int_oe_n, // Pin enable
  input wire logic tx_msg_valid, // Tx strobe
  input wire logic [MSG_W-1:0] tx_msg_type, // Tx code
  input wire logic msi_wr_valid, // MSI strobe
  input wire logic [MSI_ADDR_W-1:0] msi_wr_addr // MSI address
);
  logic [NUM_LINES-1:0] pins_r;
  always_ff @(posedge core_clk) pins_r <= pci_int_n_in;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_reset_idle: assert property ($rose(rst_n) |-> &pci_int_oe_n
    && !tx_msg_valid && !msi_wr_valid) else $error("Busy after reset");
  a_tx_hold: assert property (tx_msg_valid && !tx_msg_ready |=>
    tx_msg_valid && $stable(tx_msg_type)) else $error("Message dropped");
  a_msi_hold: assert property (msi_wr_valid && !msi_wr_ready |=>
    msi_wr_valid && $stable(msi_wr_addr)) else $error("Write dropped");
  a_msi_addr: assert property (msi_wr_valid |-> msi_wr_addr == msi_addr)
    else $error("Wrong MSI address");
  a_pins_off: assert property (msi_enable [*4] |-> &pci_int_oe_n)
    else $error("Pin driven with MSI on");
  a_rev_pin: assert property (reverse_mode && !msi_enable
    && rx_msg_valid ##1 !rx_msg_valid |=> pci_int_oe_n[$past(
    rx_msg_type[1:0], 2)] == !$past(rx_msg_type[2], 2)) else $error("Bad pin");
  a_fwd_msg: assert property ($rose(tx_msg_valid) && !$past(msi_enable)
    |-> pins_r[tx_msg_type[1:0]] == !tx_msg_type[2]) else $error("Bad code");
  a_rev_quiet: assert property (reverse_mode |-> !tx_msg_valid)
    else $error("Message in reverse mode");
endmodule
bind bridge_interrupt_mapper bridge_interrupt_mapper_chk i_chk (.*);

/* verif/bridge_interrupt_mapper_test.sv */
// Scenario bench for the interrupt mapper
`timescale 1ns/1ps
module bridge_interrupt_mapper_test;
  import irq_map_pkg::*;
  logic core_clk = 0, rst_n = 0, reverse_mode = 1, msi_enable = 0;
  logic rx_msg_valid = 0, pci_msi_valid = 0, ready;
  logic [2:0] rx_msg_type = MSG_IDLE, tx_msg_type;
  logic [3:0] pci_int_n_in = 4'hF, pci_int_n_out, pci_int_oe_n;
  logic [1:0] pci_msi_line = 2'h1;
  logic tx_msg_valid, msi_wr_valid;
  logic [63:0] msi_wr_addr;
  logic [31:0] msi_wr_data;
  logic [7:0] n_tx, n_msi;
  logic [2:0] last_tx;
  localparam logic [63:0] PROG_ADDR = 64'hFEE0_1234_5678_9ABC;
  localparam logic [31:0] PROG_DATA = 32'h0000_0041;
  int miscompares = 0, check_count = 0;
  bridge_interrupt_mapper i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .reverse_mode(reverse_mode), .msi_enable(msi_enable),
    .msi_addr(PROG_ADDR), .msi_data(PROG_DATA),
    .rx_msg_valid(rx_msg_valid), .rx_msg_type(rx_msg_type),
    .pci_int_n_in(pci_int_n_in), .pci_msi_valid(pci_msi_valid),
    .pci_msi_line(pci_msi_line), .tx_msg_ready(ready),
    .msi_wr_ready(ready), .pci_int_n_out(pci_int_n_out),
    .pci_int_oe_n(pci_int_oe_n), .tx_msg_valid(tx_msg_valid),
    .tx_msg_type(tx_msg_type), .msi_wr_valid(msi_wr_valid),
    .msi_wr_addr(msi_wr_addr), .msi_wr_data(msi_wr_data));
  irq_map_partner i_far (.core_clk(core_clk), .rst_n(rst_n),
    .tx_msg_valid(tx_msg_valid), .tx_msg_type(tx_msg_type),
    .msi_wr_valid(msi_wr_valid), .ready(ready), .n_tx(n_tx),
    .n_msi(n_msi), .last_tx(last_tx));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic report_and_stop;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_w(logic [63:0] got, logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic send(logic [2:0] t);
    @(posedge core_clk);
    rx_msg_valid <= 1'h1;
    rx_msg_type <= t;
    @(posedge core_clk);
    rx_msg_valid <= 1'h0;
    tick(3);
  endtask
  // Bounded wait on a far-side count; a hang ends the run
  task automatic wait_n(bit msi, logic [7:0] e);
    for (int i = 0; i < 60 && (msi ? n_msi : n_tx) !== e; i++) tick(1);
    if ((msi ? n_msi : n_tx) !== e) begin
      chk(msi ? n_msi : n_tx, e);
      report_and_stop();
    end
  endtask
  task automatic do_reset;
    rst_n <= 1'h0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
  endtask
  task automatic t_rev_pins;
    logic [3:0] e;
    e = 4'hF;
    for (int i = 0; i < 8; i++) begin
      send({i < 4, i[1:0]});
      send({i < 4, i[1:0]});
      e[i[1:0]] = i >= 4;
      chk(pci_int_oe_n, e);
    end
    chk(pci_int_n_out, 8'h00);
    chk(n_tx, 8'h00);
  endtask
  task automatic t_rev_msi;
    send(3'h4);
    @(posedge core_clk) msi_enable <= 1'h1;
    tick(4);
    chk(pci_int_oe_n, 8'h0F);
    @(posedge core_clk);
    rx_msg_valid <= 1'h1;
    rx_msg_type <= 3'h5;
    @(posedge core_clk) rx_msg_type <= 3'h6;
    send(3'h4);
    wait_n(1, 8'h02);
    chk(n_msi, 8'h02);
    chk_w(msi_wr_addr, PROG_ADDR);
    chk_w(64'(msi_wr_data), 64'(PROG_DATA));
    send(3'h1);
    send(3'h5);
    wait_n(1, 8'h03);
    chk(pci_int_oe_n, 8'h0F);
  endtask
  task automatic t_fwd;
    @(posedge core_clk) pci_int_n_in <= 4'h0;
    wait_n(0, 8'h04);
    chk(n_msi, 8'h00);
    chk(last_tx, 8'h07);
    @(posedge core_clk) pci_int_n_in <= 4'h4;
    wait_n(0, 8'h05);
    chk(last_tx, 8'h02);
    @(posedge core_clk) msi_enable <= 1'h1;
    @(posedge core_clk) pci_msi_valid <= 1'h1;
    @(posedge core_clk) pci_msi_valid <= 1'h0;
    wait_n(0, 8'h06);
    chk(n_tx, 8'h06);
    chk(last_tx, 8'h05);
    @(posedge core_clk) msi_enable <= 1'h0;
    tick(20);
    chk(n_tx, 8'h06);
  endtask
  initial begin
    do_reset();
    t_rev_pins();
    t_rev_msi();
    @(posedge core_clk);
    msi_enable <= 1'h0;
    reverse_mode <= 1'h0;
    do_reset();
    t_fwd();
    report_and_stop();
  end
endmodule
